// ---- core/pmc_power_ctrl.sv ----
// Power-on sequencer, reset timing and regulator registers
`timescale 1ns/1ps
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned FIRST_RESET_CYCLES = pmc_pkg::FIRST_RESET_CYC,
  parameter int unsigned LATER_RESET_CYCLES = pmc_pkg::LATER_RESET_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       key_power_on,
  input  wire logic       accessory_power_on,
  input  wire logic       charger_power_on,
  input  wire logic       host_power_good,
  input  wire logic       osc_ldo_ext_enable,
  input  wire logic       motor_ldo_ext_enable,
  input  wire logic       core_default_select,
  input  wire logic       pad_default_select,
  input  wire logic       supply_ok,
  input  wire logic       pad_at_77pct,
  input  wire logic       reset_fault,
  input  wire logic       over_temp_ok_n,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       status_read,
  output      logic [7:0] reg_rdata,
  output      logic [7:0] status_rdata,
  output      logic       power_on_out,
  output      logic       reset_out_n,
  output      logic       core_ldo_on,
  output      logic       pad_ldo_on,
  output      logic       analog_ldo_on,
  output      logic       osc_ldo_on,
  output      logic       synth_ldo_on,
  output      logic       transmit_ldo_on,
  output      logic       receive_ldo_on,
  output      logic       motor_ldo_on,
  output      logic       camera_ldo_on,
  output      logic [7:0] discharge_enable,
  output      logic [4:0] core_code,
  output      logic [4:0] pad_code,
  output      logic [4:0] motor_code,
  output      logic [4:0] camera_code,
  output      logic [2:0] analog_code,
  output      logic [2:0] osc_code,
  output      logic [2:0] receive_code,
  output      logic [2:0] synth_code,
  output      logic [2:0] transmit_code
);
  import pmc_pkg::*;

  // ==========================================================
  // Input synchronisation
  logic [6:0] sync_in;
  logic       key_s, acc_s, chg_s, pg_s, osc_pin_s, mot_pin_s, pad77_s;

  pmc_sync #(.WIDTH(7)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({key_power_on, accessory_power_on, charger_power_on, host_power_good,
                osc_ldo_ext_enable, motor_ldo_ext_enable, pad_at_77pct}),
    .sync_out (sync_in)
  );
  assign {key_s, acc_s, chg_s, pg_s, osc_pin_s, mot_pin_s, pad77_s} = sync_in;

  // Edge detection on the three power-on sources
  logic [2:0] src_d;
  logic       start_edge;
  logic       pg_d;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_d <= 3'b111;
      pg_d  <= 1'b0;
    end else begin
      src_d <= {key_s, acc_s, chg_s};
      pg_d  <= pg_s;
    end
  end
  assign start_edge = |({key_s, acc_s, chg_s} & ~src_d);

  logic pg_fall;
  assign pg_fall = pg_d & ~pg_s;

  // ==========================================================
  // Sequencer
  pmc_state_type state;
  logic          seq_load;
  logic [22:0]   seq_count;
  logic          seq_done;
  logic          power_req;

  assign power_req = key_s | acc_s | chg_s;

  pmc_timer #(.WIDTH(23)) u_seq_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (state == PMC_STANDBY),
    .load    (seq_load),
    .count   (seq_count),
    .busy    (),
    .done    (seq_done)
  );

  // Step through core, pad, analog, oscillator
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= PMC_STANDBY;
      seq_load  <= 1'b0;
      seq_count <= '0;
    end else begin
      seq_load <= 1'b0;
      if (pg_fall) begin
        state <= PMC_STANDBY;
      end else begin
        case (state)
          PMC_STANDBY: begin
            if (start_edge && supply_ok) begin
              state     <= PMC_CORE;
              seq_load  <= 1'b1;
              seq_count <= 23'(CORE_PAD_CYC);
            end
          end
          PMC_CORE: begin
            if (seq_done) begin
              state     <= PMC_PAD;
              seq_load  <= 1'b1;
              seq_count <= 23'(STEP_CYC);
            end
          end
          PMC_PAD: begin
            if (seq_done) begin
              state     <= PMC_ANA;
              seq_load  <= 1'b1;
              seq_count <= 23'(STEP_CYC);
            end
          end
          PMC_ANA: begin
            if (seq_done) begin
              state <= PMC_WAIT_PG;
            end
          end
          PMC_WAIT_PG: begin
            if (pg_s) begin
              state <= PMC_ON;
            end else if (!power_req) begin
              state <= PMC_STANDBY;
            end
          end
          PMC_ON: begin
            state <= PMC_ON;
          end
          default: state <= PMC_STANDBY;
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] pad_reg, core_reg, motor_reg, anacam_reg, oscrx_reg, syntx_reg;
  logic [7:0] enable_reg, disch_reg;
  logic       wr_ok;

  assign wr_ok = reg_write && (state != PMC_STANDBY);

  // Bus writes; power-good loss or standby restores defaults
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pad_reg    <= REG_ZERO;
      core_reg   <= REG_ZERO;
      motor_reg  <= REG_ZERO;
      anacam_reg <= REG_ZERO;
      oscrx_reg  <= REG_ZERO;
      syntx_reg  <= REG_ZERO;
      enable_reg <= REG_ZERO;
      disch_reg  <= DISCH_RST;
    end else if (state == PMC_STANDBY || pg_fall) begin
      pad_reg    <= REG_ZERO;
      core_reg   <= REG_ZERO;
      motor_reg  <= REG_ZERO;
      anacam_reg <= REG_ZERO;
      oscrx_reg  <= REG_ZERO;
      syntx_reg  <= REG_ZERO;
      enable_reg <= REG_ZERO;
      disch_reg  <= DISCH_RST;
      if (start_edge && supply_ok) begin
        // Straps caught only here at power-on
        pad_reg <= {1'b1, 2'b00, pad_default_select ? PAD_CODE_HI : PAD_CODE_LO};
        core_reg <= {3'b000, core_default_select ? CORE_CODE_HI : CORE_CODE_LO};
      end
    end else if (wr_ok) begin
      case (reg_addr)
        OFS_PAD: pad_reg <= {pad_reg[FLAG_BIT] & reg_wdata[FLAG_BIT], 2'b00, reg_wdata[4:0]};
        OFS_CORE: core_reg <= {3'b000, reg_wdata[4:0]};
        OFS_MOTOR: motor_reg <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
        OFS_ANACAM: anacam_reg <= reg_wdata;
        OFS_OSCRX: oscrx_reg <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        OFS_SYNTX: syntx_reg <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        OFS_ENABLE: enable_reg <= reg_wdata;
        OFS_DISCH: disch_reg <= reg_wdata;
        default: ;
      endcase
    end else begin
      // Sequencer turns on the default regulators in order
      case (state)
        PMC_CORE: enable_reg[EN_CORE] <= 1'b1;
        PMC_PAD: enable_reg[EN_PAD] <= 1'b1;
        PMC_ANA: enable_reg[EN_ANA] <= 1'b1;
        PMC_WAIT_PG: enable_reg[EN_OSC] <= 1'b1;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Reset output timing
  logic reset_load, reset_busy, reset_done, booted, pad_ok_d;
  logic [22:0] reset_count;
  logic pad_ok;

  assign pad_ok = pad77_s && !reset_fault && enable_reg[EN_PAD] && (state != PMC_STANDBY);

  pmc_timer #(.WIDTH(23)) u_rst_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (!pad_ok),
    .load    (reset_load),
    .count   (reset_count),
    .busy    (reset_busy),
    .done    (reset_done)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pad_ok_d    <= 1'b0;
      reset_load  <= 1'b0;
      reset_count <= '0;
      booted      <= 1'b0;
      reset_out_n <= 1'b0;
    end else begin
      pad_ok_d   <= pad_ok;
      reset_load <= pad_ok && !pad_ok_d;
      reset_count <= booted ? 23'(LATER_RESET_CYCLES) : 23'(FIRST_RESET_CYCLES);
      if (state == PMC_STANDBY || !pad_ok) begin
        reset_out_n <= 1'b0;
        if (state == PMC_STANDBY) booted <= 1'b0;
      end else if (reset_done) begin
        reset_out_n <= 1'b1;
        booted      <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Output drive from flip-flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_on_out     <= 1'b0;
      {core_ldo_on, pad_ldo_on, analog_ldo_on, osc_ldo_on} <= 4'h0;
      {synth_ldo_on, transmit_ldo_on, receive_ldo_on, motor_ldo_on, camera_ldo_on} <= 5'h0_000;
      discharge_enable <= DISCH_RST;
      reg_rdata        <= REG_ZERO;
      status_rdata     <= REG_ZERO;
      {core_code, pad_code, motor_code, camera_code} <= '0;
      {analog_code, osc_code, receive_code, synth_code, transmit_code} <= '0;
    end else begin
      power_on_out    <= key_s | acc_s | pg_s;
      core_ldo_on     <= enable_reg[EN_CORE];
      pad_ldo_on      <= enable_reg[EN_PAD];
      analog_ldo_on   <= enable_reg[EN_ANA];
      osc_ldo_on      <= enable_reg[EN_OSC] | (osc_pin_s && state != PMC_STANDBY);
      synth_ldo_on    <= enable_reg[EN_SYN];
      transmit_ldo_on <= enable_reg[EN_TX];
      receive_ldo_on  <= enable_reg[EN_RX];
      motor_ldo_on    <= motor_reg[MOTOR_DS_BIT] | (mot_pin_s && state != PMC_STANDBY);
      camera_ldo_on   <= enable_reg[EN_CAM];
      discharge_enable <= disch_reg;
      core_code       <= core_reg[4:0];
      pad_code        <= pad_reg[4:0];
      motor_code      <= motor_reg[4:0];
      camera_code     <= anacam_reg[4:0];
      analog_code     <= anacam_reg[7:5];
      osc_code        <= oscrx_reg[2:0];
      receive_code    <= oscrx_reg[6:4];
      synth_code      <= syntx_reg[2:0];
      transmit_code   <= syntx_reg[6:4];
      if (reg_read) begin
        case (reg_addr)
          OFS_PAD: reg_rdata <= pad_reg;
          OFS_CORE: reg_rdata <= core_reg;
          OFS_MOTOR: reg_rdata <= motor_reg;
          OFS_ANACAM: reg_rdata <= anacam_reg;
          OFS_OSCRX: reg_rdata <= oscrx_reg;
          OFS_SYNTX: reg_rdata <= syntx_reg;
          OFS_ENABLE: reg_rdata <= enable_reg;
          default: reg_rdata <= disch_reg;
        endcase
      end
      if (status_read) begin
        status_rdata <= REG_ZERO;
        status_rdata[ST_OSC_PIN] <= osc_pin_s;
        status_rdata[ST_MOT_PIN] <= mot_pin_s;
        status_rdata[ST_OTF]     <= over_temp_ok_n;
      end
    end
  end
endmodule : pmc_power_ctrl

// ---- include/pmc_pkg.sv ----
// Package of constants and types for the power-on and regulator control block
package pmc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CORE_PAD_US     = 200;
  localparam int unsigned STEP_US         = 100;
  localparam int unsigned FIRST_RESET_MS  = 100;
  localparam int unsigned LATER_RESET_MS  = 250;
  localparam int unsigned CORE_PAD_CYC    = CORE_PAD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STEP_CYC        = STEP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FIRST_RESET_CYC = FIRST_RESET_MS * (CLK_HZ / 1000);
  localparam int unsigned LATER_RESET_CYC = LATER_RESET_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Register offsets
  localparam logic [2:0] OFS_PAD    = 3'h0;
  localparam logic [2:0] OFS_CORE   = 3'h1;
  localparam logic [2:0] OFS_MOTOR  = 3'h2;
  localparam logic [2:0] OFS_ANACAM = 3'h3;
  localparam logic [2:0] OFS_OSCRX  = 3'h4;
  localparam logic [2:0] OFS_SYNTX  = 3'h5;
  localparam logic [2:0] OFS_ENABLE = 3'h6;
  localparam logic [2:0] OFS_DISCH  = 3'h7;

  // ==========================================================
  // Field positions
  localparam int unsigned FLAG_BIT     = 7;
  localparam int unsigned MOTOR_EN_BIT = 7;
  localparam int unsigned MOTOR_DS_BIT = 6;
  localparam int unsigned EN_PAD       = 7;
  localparam int unsigned EN_CORE      = 6;
  localparam int unsigned EN_ANA       = 5;
  localparam int unsigned EN_CAM       = 4;
  localparam int unsigned EN_OSC       = 3;
  localparam int unsigned EN_SYN       = 2;
  localparam int unsigned EN_TX        = 1;
  localparam int unsigned EN_RX        = 0;
  localparam int unsigned ST_OSC_PIN   = 0;
  localparam int unsigned ST_MOT_PIN   = 2;
  localparam int unsigned ST_OTF       = 1;

  // ==========================================================
  // Reset values
  localparam logic [4:0] CORE_CODE_HI = 5'h0_009;
  localparam logic [4:0] CORE_CODE_LO = 5'h0_000;
  localparam logic [4:0] PAD_CODE_HI  = 5'h0_019;
  localparam logic [4:0] PAD_CODE_LO  = 5'h0_009;
  localparam logic [7:0] ENABLE_RST   = 8'h0_0E8;
  localparam logic [7:0] DISCH_RST    = 8'h0_0FF;
  localparam logic [7:0] REG_ZERO     = 8'h0_000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    PMC_STANDBY, PMC_CORE, PMC_PAD, PMC_ANA, PMC_WAIT_PG, PMC_ON
  } pmc_state_type;

  // Output voltage in mV for a code, base and 50 mV step
  function automatic int unsigned pmc_code_mv(input logic [4:0] code, input int unsigned base);
    return base + 50 * code;
  endfunction : pmc_code_mv

endpackage : pmc_pkg

// ---- core/pmc_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module pmc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pmc_sync

// ---- core/pmc_timer.sv ----
// Down counter that pulses done when a loaded count expires
`timescale 1ns/1ps
module pmc_timer #(
  parameter int unsigned WIDTH = 23
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output      logic             busy,
  output      logic             done
);
  logic [WIDTH-1:0] remain;

  // Load, count down, pulse done at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remain <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (clear) begin
        busy <= 1'b0;
      end else if (load) begin
        remain <= count;
        busy   <= 1'b1;
      end else if (busy) begin
        if (remain <= 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - 1'b1;
        end
      end
    end
  end
endmodule : pmc_timer

// ---- testbench/pmc_host_model.sv ----
// Host processor model that latches the block on through power-good
`timescale 1ns/1ps
module pmc_host_model #(
  parameter int unsigned PG_DELAY = 20
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic reset_out_n,
  input  wire logic hold_on,
  output      logic host_power_good
);
  int unsigned boot_cnt;

  // ==========================================================
  // Boot after reset release, keep power-good until told to stop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_cnt        <= 0;
      host_power_good <= 1'b0;
    end else if (!hold_on) begin
      boot_cnt        <= 0;
      host_power_good <= 1'b0;  // Host shuts the block down
    end else if (reset_out_n && boot_cnt < PG_DELAY) begin
      boot_cnt <= boot_cnt + 1;
    end else if (boot_cnt == PG_DELAY) begin
      host_power_good <= 1'b1;
    end
  end
endmodule : pmc_host_model

// ---- testbench/pmc_power_ctrl_properties.sv ----
// Concurrent checks on the power-on and regulator control ports
`timescale 1ns/1ps
module pmc_power_ctrl_properties
  import pmc_pkg::*;
#(
  parameter int unsigned FIRST_RESET_CYCLES = 50,
  parameter int unsigned LATER_RESET_CYCLES = 100
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic key_power_on,
  input wire logic accessory_power_on,
  input wire logic host_power_good,
  input wire logic osc_ldo_ext_enable,
  input wire logic motor_ldo_ext_enable,
  input wire logic pad_at_77pct,
  input wire logic reset_fault,
  input wire logic reset_out_n,
  input wire logic power_on_out,
  input wire logic core_ldo_on,
  input wire logic pad_ldo_on,
  input wire logic analog_ldo_on,
  input wire logic osc_ldo_on,
  input wire logic motor_ldo_on
);
  int unsigned c_pad, c_ana, c_osc, c_rst;
  logic        rel_seen;

  // ==========================================================
  // Step counters for start-up and the reset hold
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c_pad <= 0;
      c_ana <= 0;
      c_osc <= 0;
      c_rst <= 0;
    end else begin
      c_pad <= (core_ldo_on && !pad_ldo_on) ? c_pad + 1 : 0;
      c_ana <= (pad_ldo_on && !analog_ldo_on) ? c_ana + 1 : 0;
      c_osc <= (analog_ldo_on && !osc_ldo_on) ? c_osc + 1 : 0;
      c_rst <= (pad_at_77pct && pad_ldo_on && !reset_fault && !reset_out_n) ? c_rst + 1 : 0;
    end
  end

  // Remembers a completed release until standby
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rel_seen <= 1'b0;
    end else begin
      rel_seen <= (!core_ldo_on && !host_power_good) ? 1'b0 : (reset_out_n | rel_seen);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  pwr_out_hi_a: assert property (accessory_power_on [*5] |-> power_on_out)
    else $error("power-on output low with accessory held");
  pwr_out_lo_a: assert property (
    (!key_power_on && !accessory_power_on && !host_power_good) [*5] |-> !power_on_out)
    else $error("power-on output high with all sources low");
  off_after_pg_a: assert property ($fell(host_power_good) |->
    ##[1:6] (!core_ldo_on && !pad_ldo_on && !osc_ldo_on && !reset_out_n))
    else $error("outputs still active after power-good fell");
  pad_step_a: assert property ($rose(pad_ldo_on) && !analog_ldo_on && !rel_seen |->
    c_pad >= CORE_PAD_CYC - 5 && c_pad <= CORE_PAD_CYC + 5)
    else $error("pad regulator start delay wrong");
  ana_step_a: assert property ($rose(analog_ldo_on) && !osc_ldo_on |->
    c_ana >= STEP_CYC - 5 && c_ana <= STEP_CYC + 5)
    else $error("analog regulator start delay wrong");
  osc_step_a: assert property ($rose(osc_ldo_on) && !osc_ldo_ext_enable && c_osc != 0 |->
    c_osc >= STEP_CYC - 5 && c_osc <= STEP_CYC + 5)
    else $error("oscillator regulator start delay wrong");
  first_delay_a: assert property ($rose(reset_out_n) && !rel_seen |->
    c_rst >= FIRST_RESET_CYCLES && c_rst <= FIRST_RESET_CYCLES + 10)
    else $error("first reset release delay wrong");
  later_delay_a: assert property ($rose(reset_out_n) && rel_seen |->
    c_rst >= LATER_RESET_CYCLES && c_rst <= LATER_RESET_CYCLES + 10)
    else $error("later reset release delay wrong");
  fault_drop_a: assert property (reset_fault [*4] |-> !reset_out_n)
    else $error("reset high during fault");
  osc_ext_a: assert property ((osc_ldo_ext_enable && core_ldo_on) [*5] |-> osc_ldo_on)
    else $error("oscillator regulator off with pin high");
  motor_ext_a: assert property ((motor_ldo_ext_enable && core_ldo_on) [*5] |-> motor_ldo_on)
    else $error("motor regulator off with pin high");

  // Main scenarios
  rst_rel_c: cover property ($rose(reset_out_n) && rel_seen);
  osc_on_c: cover property ($rose(osc_ldo_on) && !osc_ldo_ext_enable);
  pg_fall_c: cover property ($fell(host_power_good));
endmodule : pmc_power_ctrl_properties

bind pmc_power_ctrl pmc_power_ctrl_properties #(
  .FIRST_RESET_CYCLES(FIRST_RESET_CYCLES),
  .LATER_RESET_CYCLES(LATER_RESET_CYCLES)
) u_props (
  .ref_clk, .rst, .key_power_on, .accessory_power_on, .host_power_good,
  .osc_ldo_ext_enable, .motor_ldo_ext_enable, .pad_at_77pct, .reset_fault,
  .reset_out_n, .power_on_out, .core_ldo_on, .pad_ldo_on, .analog_ldo_on,
  .osc_ldo_on, .motor_ldo_on
);

// ---- testbench/pmic_power_on_ldo_control_tb.sv ----
// Self-checking bench for the power-on and regulator control block
`timescale 1ns/1ps
module pmic_power_on_ldo_control_tb;
  import pmc_pkg::*;
  localparam int unsigned FIRST_CYC = 50;
  localparam int unsigned LATER_CYC = 100;
  logic ref_clk, rst, key_power_on, accessory_power_on, charger_power_on, host_power_good;
  logic osc_ldo_ext_enable, motor_ldo_ext_enable, core_default_select, pad_default_select;
  logic supply_ok, pad_at_77pct, reset_fault, over_temp_ok_n, reg_write, reg_read;
  logic status_read, hold_on, power_on_out, reset_out_n, core_ldo_on, pad_ldo_on;
  logic analog_ldo_on, osc_ldo_on, synth_ldo_on, transmit_ldo_on, receive_ldo_on;
  logic motor_ldo_on, camera_ldo_on;
  logic [2:0] reg_addr, analog_code, osc_code, receive_code, synth_code, transmit_code;
  logic [4:0] core_code, pad_code, motor_code, camera_code;
  logic [7:0] reg_wdata, reg_rdata, status_rdata, discharge_enable, v;
  int         miscompares, checked;
  wire  [7:0] ldo_vec = {pad_ldo_on, core_ldo_on, analog_ldo_on, camera_ldo_on,
                         osc_ldo_on, synth_ldo_on, transmit_ldo_on, receive_ldo_on};

  pmc_power_ctrl #(.FIRST_RESET_CYCLES(FIRST_CYC), .LATER_RESET_CYCLES(LATER_CYC)) dut (
    .ref_clk, .rst, .key_power_on, .accessory_power_on, .charger_power_on, .host_power_good,
    .osc_ldo_ext_enable, .motor_ldo_ext_enable, .core_default_select, .pad_default_select,
    .supply_ok, .pad_at_77pct, .reset_fault, .over_temp_ok_n, .reg_write, .reg_read,
    .reg_addr, .reg_wdata, .status_read, .reg_rdata, .status_rdata, .power_on_out,
    .reset_out_n, .core_ldo_on, .pad_ldo_on, .analog_ldo_on, .osc_ldo_on, .synth_ldo_on,
    .transmit_ldo_on, .receive_ldo_on, .motor_ldo_on, .camera_ldo_on, .discharge_enable,
    .core_code, .pad_code, .motor_code, .camera_code, .analog_code, .osc_code,
    .receive_code, .synth_code, .transmit_code);

  pmc_host_model u_host (.ref_clk, .rst, .reset_out_n, .hold_on, .host_power_good);

  // ==========================================================
  // Clock and pad comparator that follows the pad enable
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) pad_at_77pct <= pad_ldo_on;

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  // Register or status read, compared after the loading edge
  task automatic rd(input bit st, input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_read    <= !st;
    status_read <= st;
    reg_addr    <= a;
    @(posedge ref_clk);
    reg_read    <= 1'b0;
    status_read <= 1'b0;
    @(posedge ref_clk);
    chk(st ? status_rdata : reg_rdata, exp);
  endtask : rd

  function automatic logic pick(input int sel);
    return (sel == 0) ? reset_out_n : (sel == 1) ? osc_ldo_on : core_ldo_on;
  endfunction : pick

  task automatic wait_on(input int sel, input logic val);
    int n;
    n = 0;
    while (pick(sel) !== val && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20000) begin
      miscompares++;
      $display("[ERR] %0t wait timed out", $time);
      print_verdict();
    end
  endtask : wait_on

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {key_power_on, accessory_power_on, charger_power_on, osc_ldo_ext_enable} = '0;
    {motor_ldo_ext_enable, reset_fault, reg_write, reg_read, status_read} = '0;
    {reg_addr, reg_wdata, miscompares, checked} = '0;
    {supply_ok, over_temp_ok_n, hold_on, core_default_select, pad_default_select} = 5'h1C;
    core_default_select = 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    chk(discharge_enable, DISCH_RST);
    // Start refused with supply out of range
    supply_ok        <= 1'b0;
    charger_power_on <= 1'b1;
    cyc(20);
    chk({7'h0, core_ldo_on}, 8'h00);
    charger_power_on <= 1'b0;
    supply_ok        <= 1'b1;
    cyc(5);
    // Key start-up, host latches on
    key_power_on <= 1'b1;
    wait_on(1, 1'b1);
    key_power_on <= 1'b0;
    cyc(10);
    chk({7'h0, core_ldo_on}, 8'h01);
    chk({3'h0, core_code}, {3'h0, CORE_CODE_HI});
    chk({3'h0, pad_code}, {3'h0, PAD_CODE_LO});
    rd(0, OFS_PAD, {3'h4, PAD_CODE_LO});
    rd(0, OFS_ENABLE, ENABLE_RST);
    rd(0, OFS_DISCH, DISCH_RST);
    chk({7'h0, power_on_out}, 8'h01);
    core_default_select <= 1'b0;
    pad_default_select  <= 1'b1;
    cyc(5);
    chk({3'h0, core_code}, {3'h0, CORE_CODE_HI});
    // Default flag: one keeps, zero clears, one cannot set
    wr(OFS_PAD, 8'h9F);
    rd(0, OFS_PAD, 8'h9F);
    chk({3'h0, pad_code}, 8'h1F);
    wr(OFS_PAD, 8'h0C);
    rd(0, OFS_PAD, 8'h0C);
    wr(OFS_PAD, 8'h8C);
    rd(0, OFS_PAD, 8'h0C);
    // Voltage codes at both ends of their range
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hFF : 8'h00;
      wr(OFS_ANACAM, v);
      wr(OFS_OSCRX, v & 8'h77);
      wr(OFS_SYNTX, v & 8'h77);
      wr(OFS_MOTOR, v & 8'h1F);
      cyc(2);
      chk({5'h0, analog_code}, {5'h0, v[7:5]});
      chk({3'h0, camera_code}, {3'h0, v[4:0]});
      chk({3'h0, motor_code}, {3'h0, v[4:0]});
      chk({1'b0, receive_code, 1'b0, osc_code}, v & 8'h77);
      chk({1'b0, transmit_code, 1'b0, synth_code}, v & 8'h77);
    end
    // Enable patterns, pad off drops reset, others kept
    wr(OFS_ANACAM, 8'hA5);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h5A : 8'hFF;
      wr(OFS_ENABLE, v);
      cyc(4);
      chk(ldo_vec, v);
    end
    rd(0, OFS_ANACAM, 8'hA5);
    cyc(LATER_CYC - 20);
    chk({7'h0, reset_out_n}, 8'h00);
    wait_on(0, 1'b1);
    // External enables and status pins
    wr(OFS_ENABLE, 8'hF7);
    cyc(4);
    chk({7'h0, osc_ldo_on}, 8'h00);
    osc_ldo_ext_enable <= 1'b1;
    cyc(6);
    chk({7'h0, osc_ldo_on}, 8'h01);
    rd(1, 3'h0, 8'h03);
    wr(OFS_ENABLE, 8'hFF);
    osc_ldo_ext_enable   <= 1'b0;
    motor_ldo_ext_enable <= 1'b1;
    cyc(6);
    rd(1, 3'h0, 8'h06);
    motor_ldo_ext_enable <= 1'b0;
    cyc(6);
    chk({7'h0, motor_ldo_on}, 8'h00);
    wr(OFS_MOTOR, 8'h40);
    cyc(2);
    chk({7'h0, motor_ldo_on}, 8'h01);
    wr(OFS_DISCH, 8'h5A);
    cyc(2);
    chk(discharge_enable, 8'h5A);
    // New key edge while latched on changes nothing
    key_power_on <= 1'b1;
    cyc(10);
    key_power_on <= 1'b0;
    chk({ldo_vec[7:1], reset_out_n}, 8'hFF);
    rd(0, OFS_DISCH, 8'h5A);
    // Fault forces reset low, long hold on recovery
    reset_fault <= 1'b1;
    cyc(6);
    chk({7'h0, reset_out_n}, 8'h00);
    reset_fault <= 1'b0;
    cyc(LATER_CYC - 20);
    chk({7'h0, reset_out_n}, 8'h00);
    wait_on(0, 1'b1);
    // Power-good low: shutdown, defaults, writes dropped
    hold_on <= 1'b0;
    wait_on(2, 1'b0);
    cyc(3);
    chk({ldo_vec[7:1], reset_out_n}, 8'h00);
    chk(discharge_enable, DISCH_RST);
    wr(OFS_DISCH, 8'h00);
    cyc(2);
    chk(discharge_enable, DISCH_RST);
    // Accessory start without power-good falls back to standby
    accessory_power_on <= 1'b1;
    cyc(8);
    chk({7'h0, power_on_out}, 8'h01);
    wait_on(1, 1'b1);
    accessory_power_on <= 1'b0;
    wait_on(2, 1'b0);
    cyc(6);
    chk({7'h0, power_on_out}, 8'h00);
    // Charger start with the other strap levels
    hold_on          <= 1'b1;
    charger_power_on <= 1'b1;
    wait_on(0, 1'b1);
    charger_power_on <= 1'b0;
    chk({3'h0, core_code}, {3'h0, CORE_CODE_LO});
    chk({3'h0, pad_code}, {3'h0, PAD_CODE_HI});
    rd(0, OFS_PAD, {3'h4, PAD_CODE_HI});
    print_verdict();
  end
endmodule : pmic_power_on_ldo_control_tb
